// >>> core/cspt_map.svh
// Register offsets, key and prescale codes, reset values and timing constants of the clock control block.
`ifndef CSPT_MAP_SVH
`define CSPT_MAP_SVH
`define CSPT_ADDR_PRESCALE   4'h0
`define CSPT_ADDR_FAST_TRIM  4'h1
`define CSPT_ADDR_TEMP_A     4'h2
`define CSPT_ADDR_TEMP_B     4'h3
`define CSPT_ADDR_SLOW_TRIM  4'h4
`define CSPT_ADDR_KEY        4'h5
`define CSPT_ADDR_STATUS     4'h6
`define CSPT_KEY_SIGNATURE   8'hd8
`define CSPT_KEY_WINDOW      3'h4
`define CSPT_PS_DIV1         4'h0
`define CSPT_PS_DIV8         4'h3
`define CSPT_PS_MAX          4'h8
`define CSPT_RESET_CK        8'h14
`define CSPT_WAKE_CK         8'h06
`define CSPT_MS_4            32'd4
`define CSPT_MS_64           32'd64
`define CSPT_US_60           32'd60
`define CSPT_CLK_MHZ         32'd250
`define CSPT_SLOW_KHZ        32'd32
`define CSPT_FUSE_ADD4       2'h1
`endif

// >>> core/cspt_pkg.sv
// Types shared by the clock control block.
package cspt_pkg;
   typedef enum logic [4:0] {
      CSPT_ST_RST_CK  = 5'b00001,
      CSPT_ST_RST_MS  = 5'b00010,
      CSPT_ST_RUN     = 5'b00100,
      CSPT_ST_SLEEP   = 5'b01000,
      CSPT_ST_WAKE    = 5'b10000
   } cspt_state_t;
   typedef enum logic [1:0] {
      CSPT_SRC_EXT  = 2'b00,
      CSPT_SRC_FAST = 2'b10,
      CSPT_SRC_SLOW = 2'b11
   } cspt_src_t;
endpackage : cspt_pkg

// >>> core/cspt_clock_ctrl.sv
// Start-up timer, protected clock prescaler and oscillator trim registers.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "cspt_map.svh"
module cspt_clock_ctrl #(
   parameter int unsigned MS4_TICKS  = `CSPT_MS_4 * `CSPT_SLOW_KHZ,
   parameter int unsigned MS64_TICKS = `CSPT_MS_64 * `CSPT_SLOW_KHZ,
   parameter int unsigned WAKE_BOD_CYC = `CSPT_US_60 * `CSPT_CLK_MHZ
) (
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   input  wire logic [1:0] i_clock_source_fuses,
   input  wire logic [1:0] i_startup_delay_fuses,
   input  wire logic       i_div_by_eight_fuse_n,
   input  wire logic       i_reset_pin_disabled,
   input  wire logic [7:0] i_fast_trim_factory,
   input  wire logic [7:0] i_slow_trim_factory,
   input  wire logic       i_src_ck,
   input  wire logic       i_slow_ck,
   input  wire logic       i_sleep_req,
   input  wire logic       i_wake_req,
   input  wire logic       i_brownout_detector_off,
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   output logic            o_run,
   output logic            o_sys_clk_en,
   output logic      [1:0] o_clock_sel,
   output logic      [7:0] o_fast_osc_trim,
   output logic      [7:0] o_fast_osc_temp_trim_a,
   output logic      [7:0] o_fast_osc_temp_trim_b,
   output logic      [7:0] o_slow_osc_trim
);
   cspt_pkg::cspt_state_t state;
   cspt_pkg::cspt_state_t next_state;
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic [31:0] ms_target;
   logic [1:0]  src_sync;
   logic [1:0]  slow_sync;
   logic        src_prev;
   logic        slow_prev;
   logic        src_edge;
   logic        slow_edge;
   logic [1:0]  fuse_src;
   logic [1:0]  fuse_sut;
   logic        fuse_div8_n;
   logic        fuse_rst_dis;
   logic [1:0]  next_fuse_src;
   logic [1:0]  next_fuse_sut;
   logic        next_fuse_div8_n;
   logic        next_fuse_rst_dis;
   logic [3:0]  prescale_select;
   logic [3:0]  next_prescale_select;
   logic [3:0]  active_div;
   logic [3:0]  next_active_div;
   logic [7:0]  div_cnt;
   logic [7:0]  next_div_cnt;
   logic [2:0]  key_left;
   logic [2:0]  next_key_left;
   logic [7:0]  next_fast_trim;
   logic [7:0]  next_temp_a;
   logic [7:0]  next_temp_b;
   logic [7:0]  next_slow_trim;
   logic [7:0]  next_rdata;
   logic        next_run;
   logic        next_clk_en;
   logic        first_cycle;
   logic [1:0]  next_clock_sel;

   // Terminal value of the divider for a prescale code: 2**code - 1.
   function automatic logic [7:0] div_mask(input logic [3:0] code);
      div_mask = 8'((9'h001 << code) - 9'h001);
   endfunction : div_mask

   function automatic logic [7:0] wr_byte(input logic [3:0] a, input logic [7:0] cur,
                                          input logic wr, input logic [3:0] ad,
                                          input logic [7:0] d);
      wr_byte = (wr && ad == a) ? d : cur;
   endfunction : wr_byte

   assign src_edge  = src_sync[1] & ~src_prev;
   assign slow_edge = slow_sync[1] & ~slow_prev;

   // Pin-side clocks are sampled through two flip-flops before edge detection.
   // The synchronisers keep running through reset, so a clock that is already high
   // at release is not mistaken for a rising edge and the start-up is never shortened.
   always_ff @(posedge i_clk) begin
      src_sync  <= {src_sync[0], i_src_ck};
      slow_sync <= {slow_sync[0], i_slow_ck};
      src_prev  <= src_sync[1];
      slow_prev <= slow_sync[1];
   end

   // Millisecond part of the reset delay in slow-clock ticks.
   always_comb begin
      if (fuse_sut[1]) begin
         ms_target = MS64_TICKS;
      end else if (fuse_sut == `CSPT_FUSE_ADD4 || (fuse_rst_dis && fuse_src[1])) begin
         // Only the internal oscillators get the stretch when the reset pin is off.
         ms_target = MS4_TICKS;
      end else begin
         ms_target = 32'h0;
      end
   end

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_run   = 1'b0;
      unique case (state)
         cspt_pkg::CSPT_ST_RST_CK: begin
            // Cycles count on the selected source clock.
            if (first_cycle) begin
               next_cnt = 32'h0;
            end else if (src_edge) begin
               next_cnt = cnt + 32'h1;
            end
            if (!first_cycle && cnt >= 32'(`CSPT_RESET_CK)) begin
               next_state = cspt_pkg::CSPT_ST_RST_MS;
               next_cnt   = 32'h0;
            end
         end
         cspt_pkg::CSPT_ST_RST_MS: begin
            // Milliseconds count on the 32 kHz oscillator.
            if (cnt >= ms_target) begin
               next_state = cspt_pkg::CSPT_ST_RUN;
               next_run   = 1'b1;
            end else if (slow_edge) begin
               next_cnt = cnt + 32'h1;
            end
         end
         cspt_pkg::CSPT_ST_RUN: begin
            next_run = 1'b1;
            if (i_sleep_req) begin
               next_state = cspt_pkg::CSPT_ST_SLEEP;
               next_run   = 1'b0;
            end
         end
         cspt_pkg::CSPT_ST_SLEEP: begin
            next_cnt = 32'h0;
            if (i_wake_req) begin
               next_state = cspt_pkg::CSPT_ST_WAKE;
            end
         end
         cspt_pkg::CSPT_ST_WAKE: begin
            // Disabled detector: time on the system clock so it settles.
            if (i_brownout_detector_off) begin
               next_cnt = cnt + 32'h1;
               if (cnt + 32'h1 >= WAKE_BOD_CYC) begin
                  next_state = cspt_pkg::CSPT_ST_RUN;
                  next_run   = 1'b1;
               end
            end else begin
               if (src_edge) begin
                  next_cnt = cnt + 32'h1;
               end
               if (cnt >= 32'(`CSPT_WAKE_CK)) begin
                  next_state = cspt_pkg::CSPT_ST_RUN;
                  next_run   = 1'b1;
               end
            end
         end
      endcase
   end

   always_comb begin
      next_fuse_src     = fuse_src;
      next_fuse_sut     = fuse_sut;
      next_fuse_div8_n  = fuse_div8_n;
      next_fuse_rst_dis = fuse_rst_dis;
      next_prescale_select = prescale_select;
      next_fast_trim    = wr_byte(`CSPT_ADDR_FAST_TRIM, o_fast_osc_trim, i_wr, i_addr, i_wdata);
      next_temp_a       = wr_byte(`CSPT_ADDR_TEMP_A, o_fast_osc_temp_trim_a, i_wr, i_addr,
                                  i_wdata);
      next_temp_b       = wr_byte(`CSPT_ADDR_TEMP_B, o_fast_osc_temp_trim_b, i_wr, i_addr,
                                  i_wdata);
      next_slow_trim    = wr_byte(`CSPT_ADDR_SLOW_TRIM, o_slow_osc_trim, i_wr, i_addr, i_wdata);
      next_key_left     = (key_left != 3'h0) ? key_left - 3'h1 : 3'h0;
      // Straps and factory values are caught on the first cycle after reset.
      if (first_cycle) begin
         next_fuse_src     = i_clock_source_fuses;
         next_fuse_sut     = i_startup_delay_fuses;
         next_fuse_div8_n  = i_div_by_eight_fuse_n;
         next_fuse_rst_dis = i_reset_pin_disabled;
         next_fast_trim    = i_fast_trim_factory;
         next_slow_trim    = i_slow_trim_factory;
         next_prescale_select = i_div_by_eight_fuse_n ? `CSPT_PS_DIV1 : `CSPT_PS_DIV8;
      end else if (i_wr && i_addr == `CSPT_ADDR_KEY && i_wdata == `CSPT_KEY_SIGNATURE) begin
         next_key_left = `CSPT_KEY_WINDOW;
      end else if (i_wr && i_addr == `CSPT_ADDR_PRESCALE) begin
         // Fuse state does not restrict the value; reserved codes are dropped.
         if (key_left != 3'h0 && i_wdata[3:0] <= `CSPT_PS_MAX) begin
            next_prescale_select = i_wdata[3:0];
         end
         next_key_left = 3'h0;
      end
   end

   // New factor is taken only when the divider wraps, so no short pulse appears.
   always_comb begin
      next_active_div = active_div;
      next_clk_en     = 1'b0;
      if (div_cnt >= div_mask(active_div)) begin
         next_div_cnt    = 8'h0;
         next_active_div = prescale_select;
         // Follows the next run level, so a wrap that meets a sleep request stays quiet.
         next_clk_en     = next_run;
      end else begin
         next_div_cnt = div_cnt + 8'h1;
      end
   end

   // Both external codes report one selection, so downstream sees three values only.
   always_comb begin
      if (next_fuse_src[1]) begin
         next_clock_sel = next_fuse_src;
      end else begin
         next_clock_sel = cspt_pkg::CSPT_SRC_EXT;
      end
   end

   always_comb begin
      next_rdata = 8'h0;
      if (i_rd) begin
         unique case (i_addr)
            `CSPT_ADDR_PRESCALE:  next_rdata = {4'h0, prescale_select};
            `CSPT_ADDR_FAST_TRIM: next_rdata = o_fast_osc_trim;
            `CSPT_ADDR_TEMP_A:    next_rdata = o_fast_osc_temp_trim_a;
            `CSPT_ADDR_TEMP_B:    next_rdata = o_fast_osc_temp_trim_b;
            `CSPT_ADDR_SLOW_TRIM: next_rdata = o_slow_osc_trim;
            `CSPT_ADDR_STATUS:    next_rdata = {3'h0, state};
            default:              next_rdata = 8'h0;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state        <= cspt_pkg::CSPT_ST_RST_CK;
         cnt          <= 32'h0;
         first_cycle  <= 1'b1;
         fuse_src     <= 2'h2;
         fuse_sut     <= 2'h2;
         fuse_div8_n  <= 1'b0;
         fuse_rst_dis <= 1'b0;
         prescale_select <= `CSPT_PS_DIV8;
         active_div   <= `CSPT_PS_DIV8;
         div_cnt      <= 8'h0;
         key_left     <= 3'h0;
         o_rdata      <= 8'h0;
         o_run        <= 1'b0;
         o_sys_clk_en <= 1'b0;
         o_clock_sel  <= 2'h2;
         o_fast_osc_trim        <= 8'h0;
         o_fast_osc_temp_trim_a <= 8'h0;
         o_fast_osc_temp_trim_b <= 8'h0;
         o_slow_osc_trim        <= 8'h0;
      end else begin
         state        <= next_state;
         cnt          <= next_cnt;
         first_cycle  <= 1'b0;
         fuse_src     <= next_fuse_src;
         fuse_sut     <= next_fuse_sut;
         fuse_div8_n  <= next_fuse_div8_n;
         fuse_rst_dis <= next_fuse_rst_dis;
         prescale_select <= next_prescale_select;
         active_div   <= next_active_div;
         div_cnt      <= next_div_cnt;
         key_left     <= next_key_left;
         o_rdata      <= next_rdata;
         o_run        <= next_run;
         o_sys_clk_en <= next_clk_en;
         o_clock_sel  <= next_clock_sel;
         o_fast_osc_trim        <= next_fast_trim;
         o_fast_osc_temp_trim_a <= next_temp_a;
         o_fast_osc_temp_trim_b <= next_temp_b;
         o_slow_osc_trim        <= next_slow_trim;
      end
   end
endmodule : cspt_clock_ctrl

// >>> tb/cspt_clock_ctrl_checker.sv
// Port-level assertions for the clock control block.
`timescale 1ns/1ns
module cspt_clock_ctrl_checker (
   input wire logic       i_clk,
   input wire logic       i_sys_rst,
   input wire logic [1:0] i_clock_source_fuses,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       o_run,
   input wire logic       o_sys_clk_en,
   input wire logic [1:0] o_clock_sel,
   input wire logic [7:0] o_fast_osc_trim,
   input wire logic [7:0] o_fast_osc_temp_trim_a,
   input wire logic [7:0] o_slow_osc_trim
);
   logic [15:0] low_cnt;
   logic [15:0] next_low_cnt;
   always_comb begin
      next_low_cnt = low_cnt;
      if (o_run) begin
         next_low_cnt = 16'h0000;
      end else if (low_cnt != 16'hffff) begin
         next_low_cnt = low_cnt + 16'h0001;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         low_cnt <= 16'h0000;
      end else begin
         low_cnt <= next_low_cnt;
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   a_rsvd_read_zero: assert property (
      i_rd && i_addr == 4'h0 |=> o_rdata[7:4] == 4'h0) else $error("prescale top bits set");
   a_fast_trim_write: assert property (
      i_wr && i_addr == 4'h1 |=> o_fast_osc_trim == $past(i_wdata)) else $error("fast trim lost");
   a_temp_trim_write: assert property (
      i_wr && i_addr == 4'h2 |=> o_fast_osc_temp_trim_a == $past(i_wdata))
      else $error("temp trim lost");
   a_slow_trim_write: assert property (
      i_wr && i_addr == 4'h4 |=> o_slow_osc_trim == $past(i_wdata)) else $error("slow trim lost");
   a_fast_trim_hold: assert property (
      !(i_wr && i_addr == 4'h1) && !$past(i_sys_rst) && !$past(i_sys_rst, 2)
      |=> $stable(o_fast_osc_trim)) else $error("fast trim changed unasked");
   a_clk_needs_run: assert property (
      o_sys_clk_en |-> o_run) else $error("clock enable while halted");
   a_wake_min_hold: assert property (
      $rose(o_run) |-> low_cnt >= 16'd12) else $error("run resumed too early");
   a_source_select: assert property (
      o_run |-> o_clock_sel == (i_clock_source_fuses[1] ? i_clock_source_fuses : 2'b00))
      else $error("wrong clock source");
   c_run_rise: cover property ($rose(o_run));
   c_run_fall: cover property ($fell(o_run));
   c_prescale_write: cover property (i_wr && i_addr == 4'h0);
endmodule : cspt_clock_ctrl_checker

bind cspt_clock_ctrl cspt_clock_ctrl_checker u_checker (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clock_source_fuses(i_clock_source_fuses),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_run(o_run), .o_sys_clk_en(o_sys_clk_en), .o_clock_sel(o_clock_sel),
   .o_fast_osc_trim(o_fast_osc_trim), .o_fast_osc_temp_trim_a(o_fast_osc_temp_trim_a),
   .o_slow_osc_trim(o_slow_osc_trim));

// >>> tb/cspt_clock_ctrl_tb.sv
// Self-checking bench for the clock control block.
`timescale 1ns/1ns
`include "cspt_map.svh"
module cspt_clock_ctrl_tb;
   logic       clk = 1'b0, rst = 1'b1, sck = 1'b0, lck = 1'b0, d8n = 1'b1, rpd = 1'b0;
   logic       slp = 1'b0, wk = 1'b0, bo = 1'b0, wr = 1'b0, rd = 1'b0, run, en;
   logic [1:0] csf = 2'h2, suf = 2'h0, sel;
   logic [3:0] ad = 4'h0;
   logic [7:0] wd = 8'h00, ft = 8'h5a, st = 8'h3c, rdat, tf, ta, tbb, ts;
   int         miscompares = 0, checked = 0;
   always #2 clk = ~clk;
   // Source clock is four system cycles, the slow one ten, so counts are easy to predict.
   always #8 sck = ~sck;
   always #20 lck = ~lck;
   cspt_clock_ctrl #(.MS4_TICKS(4), .MS64_TICKS(8), .WAKE_BOD_CYC(60)) dut (
      .i_clk(clk), .i_sys_rst(rst), .i_clock_source_fuses(csf), .i_startup_delay_fuses(suf),
      .i_div_by_eight_fuse_n(d8n), .i_reset_pin_disabled(rpd), .i_fast_trim_factory(ft),
      .i_slow_trim_factory(st), .i_src_ck(sck), .i_slow_ck(lck), .i_sleep_req(slp),
      .i_wake_req(wk), .i_brownout_detector_off(bo), .i_addr(ad), .i_wdata(wd), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdat), .o_run(run), .o_sys_clk_en(en), .o_clock_sel(sel),
      .o_fast_osc_trim(tf), .o_fast_osc_temp_trim_a(ta), .o_fast_osc_temp_trim_b(tbb),
      .o_slow_osc_trim(ts));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      ad <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      ad <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdat;
   endtask : rd_reg
   // Nothing else runs between the key and the field write.
   task automatic keyed(input int gap, input logic [7:0] d);
      wr_reg(`CSPT_ADDR_KEY, `CSPT_KEY_SIGNATURE);
      repeat (gap) @(posedge clk);
      wr_reg(`CSPT_ADDR_PRESCALE, d);
   endtask : keyed
   task automatic wait_for(input logic use_en, input logic v, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (((use_en ? en : run) !== v) && n < 3000);
   endtask : wait_for
   task automatic reset_case(input logic [1:0] c, s, input logic f, p, input int ms);
      int n;
      logic [7:0] v;
      @(posedge clk);
      csf <= c;
      suf <= s;
      d8n <= f;
      rpd <= p;
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      wait_for(1'b0, 1'b1, n);
      check(n >= 66 + ms * 10 && n <= 100 + ms * 10, 1'b1);
      check(sel, c[1] ? c : 2'b00);
      rd_reg(`CSPT_ADDR_PRESCALE, v);
      check(v, f ? 8'h00 : 8'h03);
      check({tf, ta, tbb, ts}, {ft, 8'h00, 8'h00, st});
      rd_reg(`CSPT_ADDR_STATUS, v);
      check(v, 8'(cspt_pkg::CSPT_ST_RUN));
   endtask : reset_case
   task automatic ps_codes();
      int n;
      logic [7:0] v;
      for (int k = 8; k >= 0; k--) begin
         keyed(0, 8'(k));
         rd_reg(`CSPT_ADDR_PRESCALE, v);
         check(v, 8'(k));
         // The new factor only lands at a divider wrap, so two periods are skipped.
         wait_for(1'b1, 1'b1, n);
         wait_for(1'b1, 1'b1, n);
         wait_for(1'b1, 1'b1, n);
         check(n, 32'(1 << k));
      end
   endtask : ps_codes
   task automatic ps_guard();
      logic [7:0] v;
      keyed(3, 8'h05);
      rd_reg(`CSPT_ADDR_PRESCALE, v);
      check(v, 8'h00);
      keyed(2, 8'h05);
      rd_reg(`CSPT_ADDR_PRESCALE, v);
      check(v, 8'h05);
      wr_reg(`CSPT_ADDR_PRESCALE, 8'h02);
      rd_reg(`CSPT_ADDR_PRESCALE, v);
      check(v, 8'h05);
      keyed(0, 8'h09);
      rd_reg(`CSPT_ADDR_PRESCALE, v);
      check(v, 8'h05);
   endtask : ps_guard
   task automatic trims();
      logic [7:0] v;
      for (int a = 1; a <= 4; a++) begin
         wr_reg(4'(a), 8'h40 + 8'(a));
      end
      wr_reg(4'h7, 8'hff);
      for (int a = 1; a <= 4; a++) begin
         rd_reg(4'(a), v);
         check(v, 8'h40 + 8'(a));
      end
      rd_reg(4'h7, v);
      check(v, 8'h00);
      check({tf, ta, tbb, ts}, 32'h41424344);
   endtask : trims
   task automatic sleep_wake(input logic off, input int lo, input int hi);
      int n;
      logic [7:0] v;
      @(posedge clk);
      bo <= off;
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      wait_for(1'b0, 1'b0, n);
      rd_reg(`CSPT_ADDR_STATUS, v);
      check(v, 8'(cspt_pkg::CSPT_ST_SLEEP));
      @(posedge clk);
      wk <= 1'b1;
      @(posedge clk);
      wk <= 1'b0;
      wait_for(1'b0, 1'b1, n);
      check(n >= lo && n <= hi, 1'b1);
   endtask : sleep_wake
   initial begin
      reset_case(2'b00, 2'b00, 1'b1, 1'b0, 0);
      reset_case(2'b01, 2'b01, 1'b0, 1'b0, 4);
      reset_case(2'b11, 2'b10, 1'b1, 1'b0, 8);
      reset_case(2'b10, 2'b00, 1'b1, 1'b1, 4);
      reset_case(2'b00, 2'b00, 1'b1, 1'b1, 0);
      reset_case(2'b10, 2'b11, 1'b0, 1'b0, 8);
      ps_codes();
      ps_guard();
      trims();
      sleep_wake(1'b0, 16, 34);
      sleep_wake(1'b1, 55, 66);
      finish_test();
   end
   // The whole sequence needs about three thousand cycles.
   initial begin
      #100000;
      miscompares++;
      finish_test();
   end
endmodule : cspt_clock_ctrl_tb
